// File: hdl/ecd_edge_clock_divider.sv
// Purpose: Edge clock path: source select, stop gate and matched divider, under AXI4-Lite.
// Assumes: Edge clock inputs are levels synchronous to core_clk and far slower than it.
// Notes:   Both clock outputs leave flip-flops loaded in the same cycle from one sample.
//
// Contract
// - Select 0 passes input zero, 1 passes one.
// - Gate runs clock at stop 0, off at 1.
// - Core logic may stop each edge clock.
// - Divider gives undivided and 2/3.5/4 divided outputs.
// - Both divider outputs have equal delay.
// - Divider input comes from edge clock mux.
// - Outputs feed primary, routing and secondary nets.
// - Divider reset forces outputs low at once.
// - Undivided output holds constant during divider reset.
// - Static ratio 2.0, 3.5 or 4.0, default 2.0.
// - Static global set/reset enable, default disabled.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`include "ecd_regs.svh"

module ecd_edge_clock_divider
    import ecd_pkg::*;
#(
    parameter ecd_ratio_type DIV_RATIO_DEFAULT = ECD_DIV_2_0,  // Ratio after reset.
    parameter logic          GSR_ENABLE_DEFAULT = 1'b0         // Global set/reset off.
)
(
    input  wire logic        core_clk,       // System clock, 125 MHz.
    input  wire logic        rst_n,          // Synchronous reset, active low.
    input  wire logic [7:0]  s_axi_awaddr,   // Write address.
    input  wire logic        s_axi_awvalid,  // Write address valid.
    output logic             s_axi_awready,  // Write address ready.
    input  wire logic [31:0] s_axi_wdata,    // Write data.
    input  wire logic [3:0]  s_axi_wstrb,    // Write byte enables.
    input  wire logic        s_axi_wvalid,   // Write data valid.
    output logic             s_axi_wready,   // Write data ready.
    output logic [1:0]       s_axi_bresp,    // Write response.
    output logic             s_axi_bvalid,   // Write response valid.
    input  wire logic        s_axi_bready,   // Write response ready.
    input  wire logic [7:0]  s_axi_araddr,   // Read address.
    input  wire logic        s_axi_arvalid,  // Read address valid.
    output logic             s_axi_arready,  // Read address ready.
    output logic [31:0]      s_axi_rdata,    // Read data.
    output logic [1:0]       s_axi_rresp,    // Read response.
    output logic             s_axi_rvalid,   // Read data valid.
    input  wire logic        s_axi_rready,   // Read data ready.
    input  wire logic        clock_in_zero,  // Edge clock source zero.
    input  wire logic        clock_in_one,   // Edge clock source one.
    output logic             undivided_out,  // Edge clock at input rate.
    output logic             divided_out     // Edge clock divided by the ratio.
);

    // ============================================================
    // Declarations.

    logic          ctrl_select_reg;   // Source choice.
    logic          ctrl_stop_reg;     // Stop request to the gate.
    logic          ctrl_divrst_reg;   // Divider reset.
    logic          ctrl_align_reg;    // Word align request level.
    logic          gsr_pulse_reg;     // Global set/reset pulse.
    ecd_ratio_type ratio_reg;         // Divide ratio in force.
    logic          gsr_enable_reg;    // Global set/reset enabled.
    logic          aw_held;           // Write address captured.
    logic          w_held;            // Write data captured.
    logic [7:0]    awaddr_reg;        // Captured write address.
    logic [31:0]   wdata_reg;         // Captured write data.
    logic          wstrb0_reg;        // Captured low byte enable.
    logic          do_write;          // Write takes effect this cycle.
    logic          write_hit;         // Captured address is mapped.
    logic [31:0]   read_value;        // Read data.
    logic          read_hit;          // Read address mapped.
    logic          mux_out;           // Chosen edge clock source.
    logic          edge_clock;        // Gated edge clock.
    logic          stop_applied;      // Stop level the gate obeys.
    logic          prev_clock_reg;    // Edge clock one cycle ago.
    logic          clock_edge;        // Either edge of the edge clock.
    logic          clock_rise;        // Rising edge of the edge clock.
    logic          align_prev_reg;    // Align request one cycle ago.
    logic          align_rise;        // New align request.
    logic          div_hold;          // Divider held in reset.
    logic          run_reg;           // Divider running.
    logic          run_next;          // Next run state.
    logic [2:0]    count_reg;         // Half-period index.
    logic [2:0]    count_next;        // Next half-period index.
    logic [1:0]    slip_reg;          // Halves to skip.
    logic [1:0]    slip_next;         // Next slip count.
    logic [2:0]    count_last;        // Last index for the ratio.
    logic [2:0]    count_high;        // Indexes below this are high.

    // ============================================================
    // Write channel.

    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;
    assign do_write      = aw_held & w_held & ~s_axi_bvalid;
    assign write_hit     = (awaddr_reg == `ECD_CONTROL_OFFSET) |
                           (awaddr_reg == `ECD_CONFIG_OFFSET) |
                           (awaddr_reg == `ECD_STATUS_OFFSET);

    // Capture address and data in either order.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            aw_held    <= 1'b0;
            w_held     <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg  <= 32'h0000_0000;
            wstrb0_reg <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            // The response is taken, so both channels open again.
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held)
            begin
                aw_held    <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held)
            begin
                w_held     <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
        end
    end

    // Answer once both are held; unmapped addresses get SLVERR.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ECD_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= write_hit ? `ECD_RESP_OKAY : `ECD_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ============================================================
    // Control and configuration registers.

    // Software levels that steer the select, the gate and the divider.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            {ctrl_align_reg, ctrl_divrst_reg, ctrl_stop_reg, ctrl_select_reg} <=
                `ECD_CTRL_RESET;
        end
        else if (do_write && wstrb0_reg && awaddr_reg == `ECD_CONTROL_OFFSET)
        begin
            ctrl_select_reg <= wdata_reg[`ECD_CTRL_SELECT_BIT];
            ctrl_stop_reg   <= wdata_reg[`ECD_CTRL_STOP_BIT];
            ctrl_divrst_reg <= wdata_reg[`ECD_CTRL_DIVRST_BIT];
            ctrl_align_reg  <= wdata_reg[`ECD_CTRL_ALIGN_BIT];
        end
    end

    // A written 1 in the pulse field gives one cycle of global set/reset.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            gsr_pulse_reg <= 1'b0;
        end
        else
        begin
            gsr_pulse_reg <= do_write && wstrb0_reg &&
                             awaddr_reg == `ECD_CONTROL_OFFSET &&
                             wdata_reg[`ECD_CTRL_GSR_BIT];
        end
    end

    // Static settings: written only while the divider is in reset.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ratio_reg      <= DIV_RATIO_DEFAULT;
            gsr_enable_reg <= GSR_ENABLE_DEFAULT;
        end
        else if (do_write && wstrb0_reg && ctrl_divrst_reg &&
                 awaddr_reg == `ECD_CONFIG_OFFSET)
        begin
            // The illegal ratio code leaves the ratio unchanged.
            if (wdata_reg[`ECD_CFG_RATIO_MSB:`ECD_CFG_RATIO_LSB] != 2'b11)
            begin
                ratio_reg <= ecd_ratio_type'(wdata_reg[`ECD_CFG_RATIO_MSB:`ECD_CFG_RATIO_LSB]);
            end
            gsr_enable_reg <= wdata_reg[`ECD_CFG_GSREN_BIT];
        end
    end

    // ============================================================
    // Read channel.

    // Select the word for the presented read address.
    always_comb
    begin
        read_value = 32'h0000_0000;
        read_hit   = 1'b1;
        unique case (s_axi_araddr)
            `ECD_CONTROL_OFFSET:
            begin
                read_value[`ECD_CTRL_SELECT_BIT] = ctrl_select_reg;
                read_value[`ECD_CTRL_STOP_BIT]   = ctrl_stop_reg;
                read_value[`ECD_CTRL_DIVRST_BIT] = ctrl_divrst_reg;
                read_value[`ECD_CTRL_ALIGN_BIT]  = ctrl_align_reg;
            end
            `ECD_CONFIG_OFFSET:
            begin
                read_value[`ECD_CFG_RATIO_MSB:`ECD_CFG_RATIO_LSB] = ratio_reg;
                read_value[`ECD_CFG_GSREN_BIT] = gsr_enable_reg;
            end
            `ECD_STATUS_OFFSET:
            begin
                read_value[`ECD_STS_STOP_BIT]  = stop_applied;
                read_value[`ECD_STS_RUN_BIT]   = run_reg;
                read_value[`ECD_STS_UNDIV_BIT] = undivided_out;
                read_value[`ECD_STS_DIV_BIT]   = divided_out;
                read_value[`ECD_STS_COUNT_MSB:`ECD_STS_COUNT_LSB] = count_reg;
            end
            default:
            begin
                // Unmapped address reads zero with an error answer.
                read_hit = 1'b0;
            end
        endcase
    end

    // One read at a time, answered the cycle after the address.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `ECD_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= read_value;
            s_axi_rresp   <= read_hit ? `ECD_RESP_OKAY : `ECD_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ============================================================
    // Source select and stop gate.

    ecd_edge_bridge_select_mux u_bridge_mux
    (
        .core_clk       (core_clk),
        .rst_n          (rst_n),
        .clock_in_zero  (clock_in_zero),
        .clock_in_one   (clock_in_one),
        .select         (ctrl_select_reg),
        .bridge_mux_out (mux_out)
    );

    ecd_edge_clock_gate u_edge_gate
    (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .edge_gate_in  (mux_out),
        .stop          (ctrl_stop_reg),
        .edge_gate_out (edge_clock),
        .stop_applied  (stop_applied)
    );

    // ============================================================
    // Edge detection on the divider input.

    // The divider clock is the gated output of the edge clock mux.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            prev_clock_reg <= 1'b0;
            align_prev_reg <= 1'b0;
        end
        else
        begin
            prev_clock_reg <= edge_clock;
            align_prev_reg <= ctrl_align_reg;
        end
    end

    assign clock_edge = edge_clock ^ prev_clock_reg;
    assign clock_rise = edge_clock & ~prev_clock_reg;
    assign align_rise = ctrl_align_reg & ~align_prev_reg;
    assign div_hold   = ctrl_divrst_reg | (gsr_pulse_reg & gsr_enable_reg);

    // ============================================================
    // Ratio decode.

    // One index per half period; 3.5 counts seven halves.
    always_comb
    begin
        unique case (ratio_reg)
            ECD_DIV_2_0:
            begin
                count_last = 3'h3;
                count_high = 3'h2;
            end
            ECD_DIV_3_5:
            begin
                count_last = 3'h6;
                count_high = 3'h4;
            end
            ECD_DIV_4_0:
            begin
                count_last = 3'h7;
                count_high = 3'h4;
            end
            default:
            begin
                count_last = 3'h3;
                count_high = 3'h2;
            end
        endcase
    end

    // ============================================================
    // Divider sequence.

    // Start on a rise, advance on every edge, skip halves on alignment.
    always_comb
    begin
        run_next   = run_reg;
        count_next = count_reg;
        slip_next  = slip_reg;
        if (!run_reg)
        begin
            if (clock_rise)
            begin
                run_next   = 1'b1;
                count_next = 3'h0;
            end
        end
        else if (clock_edge)
        begin
            if (slip_reg != 2'h0)
            begin
                // A full input period is swallowed, shifting the word boundary.
                slip_next = slip_reg - 2'h1;
            end
            else
            begin
                count_next = (count_reg == count_last) ? 3'h0 : count_reg + 3'h1;
            end
        end
        if (run_reg && align_rise)
        begin
            slip_next = `ECD_SLIP_HALVES;
        end
    end

    // Divider state; a held reset or an enabled global set/reset clears it.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || div_hold)
        begin
            run_reg   <= 1'b0;
            count_reg <= 3'h0;
            slip_reg  <= 2'h0;
        end
        else
        begin
            run_reg   <= run_next;
            count_reg <= count_next;
            slip_reg  <= slip_next;
        end
    end

    // ============================================================
    // Matched outputs.

    // Both outputs load from one edge clock sample, so they align.
    // These flops feed primary, routing and secondary nets alike.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || div_hold)
        begin
            undivided_out <= 1'b0;
            divided_out   <= 1'b0;
        end
        else
        begin
            undivided_out <= edge_clock;
            divided_out   <= run_next & (count_next < count_high);
        end
    end

endmodule // ecd_edge_clock_divider

// File: hdl/ecd_regs.svh
// Purpose: Offsets, fields, reset values and counts of the edge clock path.
// Assumes: Included by its bare name.
// Notes:   Definitions only; the package holds the types.
`ifndef ECD_REGS_SVH
`define ECD_REGS_SVH

// ============================================================
// Register byte offsets.
`define ECD_CONTROL_OFFSET   8'h00
`define ECD_CONFIG_OFFSET    8'h04
`define ECD_STATUS_OFFSET    8'h08

// ============================================================
// Control register fields.
`define ECD_CTRL_SELECT_BIT  0
`define ECD_CTRL_STOP_BIT    1
`define ECD_CTRL_DIVRST_BIT  2
`define ECD_CTRL_ALIGN_BIT   3
`define ECD_CTRL_GSR_BIT     4
`define ECD_CTRL_RESET       4'h0

// ============================================================
// Configuration register fields.
`define ECD_CFG_RATIO_LSB    0
`define ECD_CFG_RATIO_MSB    1
`define ECD_CFG_GSREN_BIT    2

// ============================================================
// Status register fields.
`define ECD_STS_STOP_BIT     0
`define ECD_STS_RUN_BIT      1
`define ECD_STS_UNDIV_BIT    2
`define ECD_STS_DIV_BIT      3
`define ECD_STS_COUNT_LSB    4
`define ECD_STS_COUNT_MSB    6

// ============================================================
// Counts and bus answers.
`define ECD_SLIP_HALVES      2'h2
`define ECD_RESP_OKAY        2'h0
`define ECD_RESP_SLVERR      2'h2

`endif

// File: hdl/ecd_pkg.sv
// Purpose: Types shared by the edge clock path.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in ecd_regs.svh.
package ecd_pkg;

    // ============================================================
    // Divide ratio of the divided output; code 2'b11 is illegal.
    typedef enum logic [1:0]
    {
        ECD_DIV_2_0 = 2'b00,   // Divide by 2.0.
        ECD_DIV_3_5 = 2'b01,   // Divide by 3.5.
        ECD_DIV_4_0 = 2'b10    // Divide by 4.0.
    } ecd_ratio_type;

endpackage

// File: hdl/ecd_edge_bridge_select_mux.sv
// Purpose: Two-input bridge select multiplexer for the edge clock sources.
// Assumes: Both clock inputs are sampled levels synchronous to core_clk.
// Notes:   Output is one flop behind the input.
module ecd_edge_bridge_select_mux
    import ecd_pkg::*;
(
    input  wire logic core_clk,       // System clock.
    input  wire logic rst_n,          // Synchronous reset, active low.
    input  wire logic clock_in_zero,  // Default source.
    input  wire logic clock_in_one,   // Alternate source.
    input  wire logic select,         // Source choice.
    output logic      bridge_mux_out  // Chosen source, registered.
);

    // ============================================================
    // Source selection.

    // Pass source zero for 0 and source one for 1.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            bridge_mux_out <= 1'b0;
        end
        else
        begin
            bridge_mux_out <= select ? clock_in_one : clock_in_zero;
        end
    end

endmodule // ecd_edge_bridge_select_mux

// File: hdl/ecd_edge_clock_gate.sv
// Purpose: Stop gate that lets core logic switch an edge clock off and on.
// Assumes: Input clock is a level on core_clk.
// Notes:   The stop request is only taken while the input is low.
module ecd_edge_clock_gate
    import ecd_pkg::*;
(
    input  wire logic core_clk,       // System clock.
    input  wire logic rst_n,          // Synchronous reset, active low.
    input  wire logic edge_gate_in,   // Clock to be gated.
    input  wire logic stop,           // 1 turns the clock off.
    output logic      edge_gate_out,  // Gated clock, registered.
    output logic      stop_applied    // Stop level that the gate obeys now.
);

    // ============================================================
    // Stop capture.

    // Take stop only in a low phase, so no pulse is cut short.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            stop_applied <= 1'b0;
        end
        else if (!edge_gate_in)
        begin
            stop_applied <= stop;
        end
    end

    // ============================================================
    // Gated output.

    // Run the clock while stop is 0 and hold it low while stop is 1.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            edge_gate_out <= 1'b0;
        end
        else
        begin
            edge_gate_out <= edge_gate_in & ~stop_applied;
        end
    end

endmodule // ecd_edge_clock_gate

// File: test/ecd_edge_clock_divider_asserts.sv
// Purpose: Port checks for the edge clock path.
// Assumes: Bound to ecd_edge_clock_divider.
// Notes:   Sees the top ports only.
// ==========
// Checker
module ecd_edge_clock_divider_asserts
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        clock_in_zero,
    input wire logic        clock_in_one,
    input wire logic        undivided_out,
    input wire logic        divided_out
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    r_unmap_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h08
        |=> s_axi_rresp == 2'h2) else $error("unmapped read not refused");
    w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    div_edge_a: assert property ($rose(divided_out) |-> $changed(undivided_out))
        else $error("divided edge without undivided edge");
    src_low_a: assert property ((!clock_in_zero && !clock_in_one) [*4] |-> !undivided_out)
        else $error("output high without source");
    src_rise_a: assert property ($rose(undivided_out) |->
        $past(clock_in_zero, 3) || $past(clock_in_one, 3)) else $error("output rise without source");
endmodule // ecd_edge_clock_divider_asserts
bind ecd_edge_clock_divider ecd_edge_clock_divider_asserts u_chk (.*);

// File: test/ecd_edge_source_model.sv
// Purpose: Edge clock sources facing the divider path.
// Assumes: Sources are slow levels on core_clk.
// Notes:   A disabled source rests low, like a stopped clock.
module ecd_edge_source_model
(
    input  wire logic core_clk,       // System clock.
    input  wire logic en_zero,        // Runs source zero.
    input  wire logic en_one,         // Runs source one.
    output logic      clock_in_zero,  // Half period of four cycles.
    output logic      clock_in_one    // Half period of six cycles.
);
    timeunit 1ns;
    timeprecision 1ps;
    int c0 = 0;  // Half period count of source zero.
    int c1 = 0;  // Half period count of source one.
    initial
    begin
        clock_in_zero = 1'b0;
        clock_in_one = 1'b0;
    end
    // ==========
    // Toggle each source after its half period.
    always @(posedge core_clk)
    begin
        c0 <= en_zero ? (c0 + 1) % 4 : 0;
        c1 <= en_one ? (c1 + 1) % 6 : 0;
        clock_in_zero <= en_zero && (c0 == 3 ? !clock_in_zero : clock_in_zero);
        clock_in_one <= en_one && (c1 == 5 ? !clock_in_one : clock_in_one);
    end
endmodule // ecd_edge_source_model

// File: test/testbench.sv
// Purpose: Self-checking bench for the edge clock path.
// Assumes: Sources from the model.
// Notes:   Clocks are judged by edge counts.
`include "ecd_regs.svh"
module testbench
    import ecd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0, rst_n = 1'b0, en_zero = 1'b0, en_one = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        clock_in_zero, clock_in_one, undivided_out, divided_out;
    int          mismatches = 0, compares = 0, ctrl_m = 0, cfg_m = 0, r, h;
    ecd_edge_clock_divider dut (.*); // One bridge mux in use.
    ecd_edge_source_model src (.*);
    initial
    forever #4 core_clk = ~core_clk;
    // Random upper bits; align bit 3 stays 0.
    function automatic logic [31:0] rnd(input logic [7:0] low);
        return ($urandom() & 32'hFFFFFF00) | low;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========
    // Bus cycles.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        if (a == `ECD_CONFIG_OFFSET && ctrl_m[2] && d[1:0] != 2'h3) cfg_m = d & 32'h7;
        if (a == `ECD_CONTROL_OFFSET) ctrl_m = d & 32'hF;
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        if (n >= 50) begin mismatches++; close_out; end
        check(s_axi_bresp, a > 8'h08 ? 2'h2 : 2'h0);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        if (n >= 50) begin mismatches++; close_out; end
        check(s_axi_rresp, a > 8'h08 ? 2'h2 : 2'h0);
    endtask
    // Count rises and cycles with an output high.
    task automatic watch(input int cyc);
        logic p;
        r = 0;
        h = 0;
        p = undivided_out;
        repeat (cyc)
        begin
            @(posedge core_clk);
            r += (undivided_out && !p);
            h += (undivided_out || divided_out);
            p = undivided_out;
        end
    endtask
    // Divided rises over 28 input periods.
    task automatic meas(input int exp);
        int u, d, n;
        logic pu, pd;
        {u, d, n, pu, pd} = {32'd0, 32'd0, 32'd0, undivided_out, divided_out};
        while (u < 29 && n < 2000)
        begin
            @(posedge core_clk);
            n++;
            u += (undivided_out && !pu);
            d += (divided_out && !pd && u > 0 && u < 29);
            {pu, pd} = {undivided_out, divided_out};
        end
        if (n >= 2000) begin mismatches++; close_out; end
        check(d, exp);
    endtask
    initial
    begin
        void'($urandom(32'hC1BB));
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`ECD_CONTROL_OFFSET);
        check(rv, ctrl_m);
        rd(`ECD_CONFIG_OFFSET);
        check(rv, cfg_m);
        rd(8'h0C);
        check(rv, 32'h0);
        wr(8'h10, rnd(8'h07));
        en_zero <= 1'b1;
        meas(14);
        wr(`ECD_CONTROL_OFFSET, rnd(8'h01));
        watch(60);
        check(r, 0);
        en_one <= 1'b1;
        watch(60);
        check(r > 3, 1);
        wr(`ECD_CONTROL_OFFSET, rnd(8'h02));
        watch(20);
        watch(60);
        check(r, 0);
        rd(`ECD_STATUS_OFFSET);
        check(rv[0], 1'b1);
        wr(`ECD_CONTROL_OFFSET, rnd(8'h00));
        watch(60);
        check(r > 3, 1);
        for (int i = 1; i < 3; i++)
        begin
            wr(`ECD_CONFIG_OFFSET, rnd(i));
            wr(`ECD_CONTROL_OFFSET, rnd(8'h04));
            watch(20);
            watch(60);
            check(h, 0);
            wr(`ECD_CONFIG_OFFSET, rnd(8'h03));
            wr(`ECD_CONFIG_OFFSET, rnd(i));
            rd(`ECD_CONFIG_OFFSET);
            check(rv, cfg_m);
            wr(`ECD_CONTROL_OFFSET, rnd(8'h00));
            meas(i == 1 ? 8 : 7);
        end
        wr(`ECD_CONTROL_OFFSET, rnd(8'h04));
        wr(`ECD_CONFIG_OFFSET, rnd(8'h04));
        wr(`ECD_CONTROL_OFFSET, rnd(8'h00));
        wr(`ECD_CONTROL_OFFSET, rnd(8'h10));
        rd(`ECD_CONTROL_OFFSET);
        check(rv, ctrl_m);
        meas(14);
        close_out;
    end
endmodule // testbench
